// ---- common/mul_pkg.sv ----
// Constants and types for the 8x8 multiply datapath.
package mul_pkg;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned PROD_W        = 16;
    localparam int unsigned QUARTERS      = 4;
    localparam logic [1:0]  Q_DECODE      = 2'h0;
    localparam logic [1:0]  Q_READ        = 2'h1;
    localparam logic [1:0]  Q_PROCESS     = 2'h2;
    localparam logic [1:0]  Q_WRITE       = 2'h3;
    localparam logic [7:0]  PROD_HI_RESET = 8'h00;
    localparam logic [7:0]  PROD_LO_RESET = 8'h00;
    localparam logic [7:0]  ACCESS_BANK   = 8'h00;

    typedef enum logic [1:0] {
        OP_NONE    = 2'b00,
        OP_LITERAL = 2'b01,
        OP_FILE    = 2'b10
    } mul_op_t;
endpackage

// ---- hw/mul_8x8.sv ----
// Combinational 8x8 unsigned multiplier.
`timescale 1ns/10ps
module mul_8x8 (
    input  wire logic [7:0]  factor_a, // First factor.
    input  wire logic [7:0]  factor_b, // Second factor.
    output logic      [15:0] product   // Full unsigned product.
);
    always_comb begin
        product = 16'(factor_a) * 16'(factor_b);
    end
endmodule // mul_8x8

// ---- hw/multiply_unit.sv ----
// Multiply execution unit: literal and file forms, writing the product pair.
//
// Behaviour
// RQ1 - Literal form: accumulator times immediate, 16-bit product.
// RQ2 - File form: high byte and low byte split.
// RQ3 - Eight-bit file address, byte only read.
// RQ4 - Access bit selects access bank or pointer.
// RQ5 - No flags or accumulator changed.
// RQ6 - One cycle: read Q2, write Q4.
`timescale 1ns/10ps
module multiply_unit (
    input  wire logic        core_clk,            // Core clock, 40 MHz.
    input  wire logic        reset,               // Synchronous reset, active high.
    input  wire logic        quarter_en,          // Quarter enable; each cycle it is high while a multiply is busy and instr_start is low advances the quarter counter.
    input  wire logic        instr_start,         // Pulse in Q1 when a new instruction is decoded.
    input  wire logic        multiply_by_literal_op, // Decoded literal multiply.
    input  wire logic        multiply_by_file_op, // Decoded file multiply.
    input  wire logic [7:0]  operand_field,       // Immediate or file address.
    input  wire logic        access_sel,          // 0 access bank, 1 pointer bank.
    input  wire logic [7:0]  accumulator,         // Working accumulator (read only).
    input  wire logic [7:0]  bank_select_pointer, // Bank pointer register.
    output logic      [15:0] file_read_addr,      // Bank and offset of byte to read.
    output logic             file_read_en,        // Read strobe, Q2 of a file multiply.
    input  wire logic [7:0]  file_read_data,      // Byte returned from the general_purpose_file.
    output logic [7:0]       product_high_byte,   // Upper product byte.
    output logic [7:0]       product_low_byte,    // Lower product byte.
    output logic             product_write        // Pulse when the pair is written.
);
    typedef struct packed {
        logic [1:0]      quarter;
        mul_pkg::mul_op_t op;
        logic [7:0]      operand;
        logic [7:0]      factor;
        logic [7:0]      prod_hi;
        logic [7:0]      prod_lo;
        logic            wr;
        logic            busy;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic [15:0] product;

    mul_8x8 u_mul (
        .factor_a (accumulator),
        .factor_b (state_reg.factor),
        .product  (product)
    );

    // The bank comes from the instruction bit, not from any latched state.
    always_comb begin
        file_read_addr = {(access_sel ? bank_select_pointer : mul_pkg::ACCESS_BANK), state_reg.operand}; // [RQ3] [RQ4]
        file_read_en   = state_reg.busy && (state_reg.op == mul_pkg::OP_FILE) &&
                         (state_reg.quarter == mul_pkg::Q_READ) && quarter_en; // [RQ6]
    end

    always_comb begin
        state_next    = state_reg;
        state_next.wr = 1'b0;
        if (instr_start) begin
            state_next.quarter = mul_pkg::Q_DECODE;
            state_next.operand = operand_field;
            state_next.busy    = multiply_by_literal_op | multiply_by_file_op;
            if (multiply_by_file_op) begin
                state_next.op = mul_pkg::OP_FILE;
            end else if (multiply_by_literal_op) begin
                state_next.op = mul_pkg::OP_LITERAL;
            end else begin
                state_next.op = mul_pkg::OP_NONE;
            end
        end else if (state_reg.busy && quarter_en) begin
            state_next.quarter = state_reg.quarter + 2'h1;
            case (state_reg.quarter)
                mul_pkg::Q_READ: begin
                    // The file byte is sampled only; nothing writes memory here.
                    state_next.factor = (state_reg.op == mul_pkg::OP_FILE) ?
                                        file_read_data : state_reg.operand; // [RQ1] [RQ3] [RQ6]
                end
                mul_pkg::Q_WRITE: begin
                    state_next.prod_hi = product[15:8]; // [RQ1] [RQ2] [RQ6]
                    state_next.prod_lo = product[7:0];  // [RQ2]
                    state_next.wr      = 1'b1;
                    state_next.busy    = 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= '{quarter: mul_pkg::Q_DECODE, op: mul_pkg::OP_NONE, operand: 8'h00, factor: 8'h00,
                           prod_hi: mul_pkg::PROD_HI_RESET, prod_lo: mul_pkg::PROD_LO_RESET,
                           wr: 1'b0, busy: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // No flag or accumulator output exists, so neither can be disturbed.
    assign product_high_byte = state_reg.prod_hi; // [RQ5]
    assign product_low_byte  = state_reg.prod_lo;
    assign product_write     = state_reg.wr;
endmodule // multiply_unit

// ---- tb/multiply_unit_asserts.sv ----
// Port assertions for the multiply execution unit.
`timescale 1ns/10ps
module multiply_unit_checker (
    input wire logic core_clk, reset, quarter_en, instr_start, multiply_by_literal_op, multiply_by_file_op, access_sel,
    input wire logic [7:0] operand_field, accumulator, bank_select_pointer, file_read_data, product_high_byte,
    input wire logic [7:0] product_low_byte,
    input wire logic [15:0] file_read_addr,
    input wire logic file_read_en, product_write
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_bank; file_read_en |-> file_read_addr[15:8] == (access_sel ? bank_select_pointer : mul_pkg::ACCESS_BANK);
    endproperty
    a_bank: assert property (p_bank) else $error("read bank wrong");
    property p_offs; file_read_en |-> file_read_addr[7:0] == operand_field && multiply_by_file_op; endproperty
    a_offs: assert property (p_offs) else $error("read offset wrong");
    property p_rdq; file_read_en |-> quarter_en && multiply_by_file_op && !product_write; endproperty
    a_rdq: assert property (p_rdq) else $error("read outside quarter");
    property p_wrq; product_write |-> $past(quarter_en); endproperty
    a_wrq: assert property (p_wrq) else $error("write off quarter");
    property p_file; product_write && multiply_by_file_op
        |-> {product_high_byte, product_low_byte} == 16'(accumulator) * file_read_data; endproperty
    a_file: assert property (p_file) else $error("file product wrong");
    property p_pulse; product_write |=> !product_write; endproperty
    a_pulse: assert property (p_pulse) else $error("write not a pulse");
    property p_hold; $changed({product_high_byte, product_low_byte}) |-> product_write; endproperty
    a_hold: assert property (p_hold) else $error("product moved");
    property p_lit; product_write && multiply_by_literal_op && !multiply_by_file_op
        |-> {product_high_byte, product_low_byte} == 16'(accumulator) * operand_field; endproperty
    a_lit: assert property (p_lit) else $error("literal product wrong");
endmodule // multiply_unit_checker
bind multiply_unit multiply_unit_checker multiply_unit_checker_i (.*);

// ---- tb/testbench.sv ----
// Self-checking bench for the multiply execution unit.
`timescale 1ns/10ps
module testbench;
    logic core_clk = 1'b0, reset = 1'b1, quarter_en = 1'b0, instr_start = 1'b0, access_sel = 1'b0;
    logic multiply_by_literal_op = 1'b0, multiply_by_file_op = 1'b0, file_read_en, product_write;
    logic [7:0] operand_field = 8'h00, accumulator = 8'h00, bank_select_pointer = 8'h00, file_read_data = 8'h00;
    logic [7:0] product_high_byte, product_low_byte;
    logic [15:0] file_read_addr, exp_q[$], addr_q[$];
    logic [31:0] r = 32'h0345;
    int num_errors = 0, comparisons = 0;
    always #12.5 core_clk = ~core_clk;
    multiply_unit multiply_unit_i (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] s); return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]}; endfunction
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (e !== g) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic run_op(input logic lt, fl, as, input logic [7:0] acc, opd, rd);
        @(posedge core_clk);
        {multiply_by_literal_op, multiply_by_file_op, access_sel, accumulator, operand_field} <= {lt, fl, as, acc, opd};
        file_read_data <= rd;
        instr_start <= 1'b1;
        if (fl) addr_q.push_back({(as ? bank_select_pointer : mul_pkg::ACCESS_BANK), opd});
        if (fl) exp_q.push_back(16'(acc) * rd);
        else if (lt) exp_q.push_back(16'(acc) * opd);
        @(posedge core_clk) {instr_start, quarter_en} <= 2'b01;
        repeat (4) @(posedge core_clk);
        quarter_en <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    // The pair is read at the edge that sees the write pulse, so both come from the same cycle.
    always @(posedge core_clk) begin
        if (!reset && product_write === 1'b1) begin
            if (exp_q.size() == 0) check("stray write", 16'h0000, 16'hffff);
            else check("product pair", exp_q.pop_front(), {product_high_byte, product_low_byte});
        end
        if (!reset && file_read_en === 1'b1) begin
            if (addr_q.size() == 0) check("stray read", 16'h0000, 16'hffff);
            else check("read address", addr_q.pop_front(), file_read_addr);
        end
    end
    task automatic test_done();
        check("pending writes", 16'h0000, 16'(exp_q.size() + addr_q.size()));
        $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        run_op(1'b1, 1'b0, 1'b0, 8'hff, 8'hff, 8'h00);
        run_op(1'b0, 1'b1, 1'b1, 8'hff, 8'hff, 8'hff);
        run_op(1'b0, 1'b0, 1'b0, 8'h12, 8'h34, 8'h56);
        // A reset in mid-run must clear the pair left by the file multiply above.
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        check("reset pair", {mul_pkg::PROD_HI_RESET, mul_pkg::PROD_LO_RESET}, {product_high_byte, product_low_byte});
        reset <= 1'b0;
        $display("Boundary operations done");
        for (int i = 0; i < 40; i++) begin
            r = lfsr(r);
            bank_select_pointer <= r[31:24];
            run_op(r[0], r[1], r[2], r[15:8], r[23:16], r[31:24] ^ 8'h5a);
        end
        $display("Random operations done");
        test_done();
    end
    initial begin
        #(25 * 2000);
        num_errors++;
        test_done();
    end
endmodule // testbench
